// file: verilog/cio_map.svh
// constants for the channel I/O mapping and failsafe block
`ifndef CIO_MAP_SVH
`define CIO_MAP_SVH
// --------------------------------------------------------------
// configuration byte map
// --------------------------------------------------------------
`define CIO_NCH 32'h10
`define CIO_CFG_BYTES 32'hD0
`define CIO_OFS_MODE 32'h1F
`define CIO_OFS_MAP 32'h20
`define CIO_OFS_MON 32'h30
`define CIO_OFS_FS 32'h50
`define CIO_OFS_RST 32'h60
`define CIO_OFS_KIND 32'h70
`define CIO_OFS_POL 32'h80
`define CIO_OFS_FILT 32'h90
`define CIO_OFS_FN 32'hC0
// --------------------------------------------------------------
// field codes and reset values
// --------------------------------------------------------------
`define CIO_MODE_FREE 8'h04
`define CIO_MAP_NONE 8'h10
`define CIO_MON_DFLT 8'h50
`define CIO_MON_MAX 8'hFF
`define CIO_FS_LOW 2'h0
`define CIO_FS_HIGH 2'h1
`define CIO_FN_OFF 8'h00
`define CIO_FN_DO 8'h01
`define CIO_FN_DI 8'h02
`define CIO_FN_AUX 8'h04
`define CIO_KIND_PP 8'h00
`define CIO_ERR_NONE 8'h00
`define CIO_ERR_MAP 8'h01
`define CIO_ERR_MODE 8'h02
// --------------------------------------------------------------
// timing
// --------------------------------------------------------------
`define CIO_CLK_PERIOD_NS 4
`define CIO_MS_NS 1000000
`define CIO_DO_FILT_MS 3'h5
`define CIO_DI_F1_MS 4'h1
`define CIO_DI_F2_MS 4'h2
`define CIO_DI_F3_MS 4'h3
`define CIO_DI_F4_MS 4'h6
`define CIO_DI_F5_MS 4'hA
`define CIO_DI_F6_MS 4'hF
`endif

// file: verilog/cio_pkg.sv
// types shared by the channel I/O mapping block
package cio_pkg;
  typedef logic [7:0] cio_byte_t;
  typedef logic [15:0] cio_word_t;
  typedef logic [4:0] cio_pos_t;
endpackage

// file: verilog/cio_channel_map.sv
// channel I/O mapping, output monitoring, failsafe and input filtering
`timescale 1ns/10ps
`include "cio_map.svh"
module cio_channel_map #(
  parameter int MS_CYCLES = `CIO_MS_NS / `CIO_CLK_PERIOD_NS,
  parameter logic [7:0] RESTART_MS = 8'h64,
  parameter logic [7:0] FUNC_RESET = `CIO_FN_DI
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CFG_WR,
  input wire cio_pkg::cio_byte_t CFG_ADDR,
  input wire cio_pkg::cio_byte_t CFG_WDATA,
  input wire logic CFG_APPLY,
  output wire cio_pkg::cio_byte_t CFG_RDATA,
  output wire logic CFG_DONE,
  output wire cio_pkg::cio_byte_t CFG_ERR,
  input wire cio_pkg::cio_word_t OUT_WORD,
  output wire cio_pkg::cio_word_t IN_WORD,
  input wire logic DEV_ERR,
  input wire logic CTRL_STOP,
  input wire logic LINK_LOST,
  input wire cio_pkg::cio_word_t PIN_IN,
  input wire cio_pkg::cio_word_t OVERLOAD,
  output wire cio_pkg::cio_word_t PIN_OUT,
  output wire cio_pkg::cio_word_t PIN_OE,
  output wire cio_pkg::cio_word_t DO_FAULT
);
  import cio_pkg::*;

  // ------------------------------------------------------------
  // configuration store
  // ------------------------------------------------------------
  // writes land in a shadow copy; apply copies it whole so that a
  // rejected set never leaves a half-updated channel behind
  cio_byte_t shad_q [`CIO_CFG_BYTES];
  cio_byte_t act_q [`CIO_CFG_BYTES];
  cio_byte_t rdata_q;
  cio_byte_t err_q;
  logic done_q;
  logic addr_ok;
  logic map_ok;
  logic mode_ok;

  function automatic cio_byte_t dflt(int a);
    cio_byte_t v;
    v = 8'h00;
    if (a >= `CIO_OFS_MAP && a < `CIO_OFS_MAP + `CIO_NCH) begin
      v = 8'(a - `CIO_OFS_MAP);
    end else if (a >= `CIO_OFS_MON && a < `CIO_OFS_FS) begin
      if (((a - `CIO_OFS_MON) % 2) == 0) begin
        v = `CIO_MON_DFLT;
      end
    end else if (a >= `CIO_OFS_FN && a < `CIO_CFG_BYTES) begin
      v = FUNC_RESET;
    end
    return v;
  endfunction

  assign addr_ok = {24'h0, CFG_ADDR} < `CIO_CFG_BYTES;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int a = 0; a < `CIO_CFG_BYTES; a++) begin
        shad_q[a] <= dflt(a);
      end
    end else if (CFG_WR && addr_ok) begin
      shad_q[CFG_ADDR] <= CFG_WDATA;
    end
  end

  // duplicate bits or out-of-range entries invalidate the set
  always_comb begin
    map_ok = 1'b1;
    for (int i = 0; i < `CIO_NCH; i++) begin
      if (shad_q[`CIO_OFS_MAP + i] > `CIO_MAP_NONE) begin
        map_ok = 1'b0;
      end
      for (int j = i + 1; j < `CIO_NCH; j++) begin
        if (shad_q[`CIO_OFS_MAP + i] != `CIO_MAP_NONE &&
            shad_q[`CIO_OFS_MAP + i] == shad_q[`CIO_OFS_MAP + j]) begin
          map_ok = 1'b0;
        end
      end
    end
    mode_ok = shad_q[`CIO_OFS_MODE] <= `CIO_MODE_FREE;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int a = 0; a < `CIO_CFG_BYTES; a++) begin
        act_q[a] <= dflt(a);
      end
    end else if (CFG_APPLY && map_ok && mode_ok) begin
      for (int a = 0; a < `CIO_CFG_BYTES; a++) begin
        act_q[a] <= shad_q[a];
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      done_q <= 1'b0;
      err_q <= `CIO_ERR_NONE;
      rdata_q <= 8'h00;
    end else begin
      done_q <= CFG_APPLY;
      rdata_q <= addr_ok ? shad_q[CFG_ADDR] : 8'h00;
      if (CFG_APPLY) begin
        if (!map_ok) begin
          err_q <= `CIO_ERR_MAP;
        end else if (!mode_ok) begin
          err_q <= `CIO_ERR_MODE;
        end else begin
          err_q <= `CIO_ERR_NONE;
        end
      end
    end
  end

  assign CFG_RDATA = rdata_q;
  assign CFG_DONE = done_q;
  assign CFG_ERR = err_q;

  // ------------------------------------------------------------
  // millisecond tick
  // ------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic ms_tick_q;

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      tick_cnt_q <= 32'h0;
      ms_tick_q <= 1'b0;
    end else if (tick_cnt_q == 32'(MS_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0;
      ms_tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      ms_tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // channel to bit mapping
  // ------------------------------------------------------------
  // channel index c: bit 0 selects pin B, bits 3:1 the port
  function automatic logic [3:0] fixed_pos(logic [2:0] m,
                                           logic [3:0] c);
    logic [3:0] p;
    p = c;
    case (m)
      3'h1: p = {~c[3], c[2:0]};
      3'h2: p = {c[0], c[3:1]};
      3'h3: p = {~c[0], c[3:1]};
      default: p = c;
    endcase
    return p;
  endfunction

  cio_pos_t pos [`CIO_NCH];
  cio_word_t cmd_w;
  cio_word_t di_w;
  cio_word_t in_d;
  cio_word_t in_q;
  logic fs;
  logic free_mode;

  assign free_mode = act_q[`CIO_OFS_MODE] == `CIO_MODE_FREE;
  assign fs = DEV_ERR | CTRL_STOP | LINK_LOST;

  always_comb begin
    in_d = 16'h0000;
    for (int c = 0; c < `CIO_NCH; c++) begin
      if (free_mode) begin
        pos[c] = act_q[`CIO_OFS_MAP + c][4:0];
      end else begin
        pos[c] = {1'b0, fixed_pos(act_q[`CIO_OFS_MODE][2:0], 4'(c))};
      end
      // one position serves both directions
      cmd_w[c] = pos[c][4] ? 1'b0 : OUT_WORD[pos[c][3:0]];
      if (!pos[c][4]) begin
        in_d[pos[c][3:0]] = in_d[pos[c][3:0]] | di_w[c];
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      in_q <= 16'h0000;
    end else begin
      in_q <= in_d;
    end
  end

  assign IN_WORD = in_q;

  // ------------------------------------------------------------
  // per-channel logic
  // ------------------------------------------------------------
  cio_word_t pin_w;
  cio_word_t oe_w;
  cio_word_t flt_w;

  genvar c;
  generate
    for (c = 0; c < `CIO_NCH; c++) begin : g_ch
      cio_byte_t fn;
      cio_byte_t fn_a;
      cio_byte_t dly;
      logic [1:0] fs_code;
      logic auto_rst;
      logic eff;
      logic [3:0] lim;
      logic [7:0] mon_q;
      logic prev_q;
      logic [2:0] filt_q;
      logic trip_q;
      logic [7:0] retry_q;
      logic last_q;
      logic pin_q;
      logic oe_q;
      logic di_q;
      logic [3:0] dcnt_q;

      // an inactive pin A takes its pin B down with it
      assign fn_a = act_q[`CIO_OFS_FN + (c / 2) * 2];
      assign fn = (fn_a == `CIO_FN_OFF) ? `CIO_FN_OFF
                                        : act_q[`CIO_OFS_FN + c];
      assign dly = (act_q[`CIO_OFS_MON + 2 * c + 1] != 8'h00)
                   ? `CIO_MON_MAX : act_q[`CIO_OFS_MON + 2 * c];
      assign fs_code = act_q[`CIO_OFS_FS + c][1:0];
      assign auto_rst = act_q[`CIO_OFS_RST + c][0];

      always_comb begin
        if (!fs) begin
          eff = cmd_w[c];
        end else if (fs_code == `CIO_FS_LOW) begin
          eff = 1'b0;
        end else if (fs_code == `CIO_FS_HIGH) begin
          eff = 1'b1;
        end else begin
          eff = last_q;
        end
      end

      // monitoring blanking after switch-on
      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          prev_q <= 1'b0;
          mon_q <= 8'h00;
        end else begin
          prev_q <= eff;
          if (eff && !prev_q) begin
            mon_q <= dly;
          end else if (ms_tick_q && mon_q != 8'h00) begin
            mon_q <= mon_q - 8'h01;
          end
        end
      end

      // fault qualification and overload trip
      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          filt_q <= 3'h0;
          trip_q <= 1'b0;
          retry_q <= 8'h00;
        end else begin
          if (fn != `CIO_FN_DO || !eff || trip_q ||
              mon_q != 8'h00 || !OVERLOAD[c]) begin
            filt_q <= 3'h0;
          end else if (ms_tick_q && filt_q != `CIO_DO_FILT_MS) begin
            filt_q <= filt_q + 3'h1;
          end
          if (filt_q == `CIO_DO_FILT_MS) begin
            trip_q <= 1'b1;
            retry_q <= 8'h00;
          end else if (trip_q && auto_rst) begin
            if (ms_tick_q) begin
              if (retry_q == RESTART_MS) begin
                trip_q <= 1'b0;
              end else begin
                retry_q <= retry_q + 8'h01;
              end
            end
          end else if (trip_q && !eff) begin
            // without restart only a logical reset re-arms
            trip_q <= 1'b0;
          end
        end
      end

      // pin drive
      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          last_q <= 1'b0;
          pin_q <= 1'b0;
          oe_q <= 1'b0;
        end else begin
          if (!fs) begin
            last_q <= cmd_w[c];
          end
          case (fn)
            `CIO_FN_DO: begin
              pin_q <= eff & ~trip_q;
              // high-side drivers only source, low is released
              oe_q <= (act_q[`CIO_OFS_KIND + c] == `CIO_KIND_PP) |
                      (eff & ~trip_q);
            end
            `CIO_FN_AUX: begin
              pin_q <= 1'b1;
              oe_q <= 1'b1;
            end
            default: begin
              pin_q <= 1'b0;
              oe_q <= 1'b0;
            end
          endcase
        end
      end

      always_comb begin
        case (act_q[`CIO_OFS_FILT + c])
          8'h01: lim = `CIO_DI_F1_MS;
          8'h02: lim = `CIO_DI_F2_MS;
          8'h03: lim = `CIO_DI_F3_MS;
          8'h04: lim = `CIO_DI_F4_MS;
          8'h05: lim = `CIO_DI_F5_MS;
          8'h06: lim = `CIO_DI_F6_MS;
          default: lim = 4'h0;
        endcase
      end

      // input filter, ms granularity so a new level can pass up to
      // one tick early
      always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
          di_q <= 1'b0;
          dcnt_q <= 4'h0;
        end else if (lim == 4'h0 || PIN_IN[c] == di_q) begin
          di_q <= PIN_IN[c];
          dcnt_q <= 4'h0;
        end else if (ms_tick_q) begin
          if (dcnt_q + 4'h1 >= lim) begin
            di_q <= PIN_IN[c];
            dcnt_q <= 4'h0;
          end else begin
            dcnt_q <= dcnt_q + 4'h1;
          end
        end
      end

      assign di_w[c] = (fn == `CIO_FN_DI) &
                       (di_q ^ act_q[`CIO_OFS_POL + c][0]);
      assign pin_w[c] = pin_q;
      assign oe_w[c] = oe_q;
      assign flt_w[c] = trip_q;
    end
  endgenerate

  assign PIN_OUT = pin_w;
  assign PIN_OE = oe_w;
  assign DO_FAULT = flt_w;

endmodule

// file: tb/cio_channel_map_assertions.sv
// port checker for the channel I/O mapping block
`timescale 1ns/10ps
module cio_map_chk #(
  parameter int MS_CYCLES = 10
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CFG_WR,
  input wire cio_pkg::cio_byte_t CFG_ADDR,
  input wire logic CFG_APPLY,
  input wire cio_pkg::cio_byte_t CFG_RDATA,
  input wire logic CFG_DONE,
  input wire cio_pkg::cio_byte_t CFG_ERR,
  input wire logic DEV_ERR,
  input wire logic CTRL_STOP,
  input wire logic LINK_LOST,
  input wire cio_pkg::cio_word_t OVERLOAD,
  input wire cio_pkg::cio_word_t PIN_OUT,
  input wire cio_pkg::cio_word_t DO_FAULT
);
  import cio_pkg::*;
  logic [31:0] ov_run_q;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  // wide count so the default ms length cannot wrap
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) ov_run_q <= '0;
    else if (!OVERLOAD[0]) ov_run_q <= '0;
    else ov_run_q <= ov_run_q + 32'h1;
  end
  sequence s_quiet_addr;
    !CFG_WR ##1 $stable(CFG_ADDR);
  endsequence
  sequence s_tripped;
    (DO_FAULT[0] && !(DEV_ERR || CTRL_STOP || LINK_LOST)) [*2];
  endsequence
  a_done_after_apply: assert property (CFG_APPLY |=> CFG_DONE)
    else $error("no done after apply");
  a_done_has_cause: assert property (CFG_DONE |-> $past(CFG_APPLY))
    else $error("done without apply");
  a_err_holds: assert property (!CFG_APPLY |=> $stable(CFG_ERR))
    else $error("error code moved without apply");
  a_err_code_set: assert property (CFG_DONE |-> CFG_ERR <= 8'h02)
    else $error("error code out of range");
  a_rdata_unmapped: assert property
    ($past(CFG_ADDR) >= 8'hD0 |-> CFG_RDATA == 8'h00)
    else $error("read beyond table not zero");
  a_rdata_steady: assert property (s_quiet_addr |=> $stable(CFG_RDATA))
    else $error("read data moved with no write");
  a_fault_filtered: assert property
    ($rose(DO_FAULT[0]) |-> $past(ov_run_q) >= 32'(4 * MS_CYCLES))
    else $error("fault flagged before filter time");
  a_trip_pin_off: assert property (s_tripped |-> !PIN_OUT[0])
    else $error("tripped output still driven high");
endmodule
bind cio_channel_map cio_map_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .CFG_WR(CFG_WR), .CFG_ADDR(CFG_ADDR),
  .CFG_APPLY(CFG_APPLY), .CFG_RDATA(CFG_RDATA), .CFG_DONE(CFG_DONE),
  .CFG_ERR(CFG_ERR), .DEV_ERR(DEV_ERR), .CTRL_STOP(CTRL_STOP),
  .LINK_LOST(LINK_LOST), .OVERLOAD(OVERLOAD), .PIN_OUT(PIN_OUT),
  .DO_FAULT(DO_FAULT)
);

// file: tb/cio_ctrl_model.sv
// behavioural network controller sending the cyclic output word
`timescale 1ns/10ps
module cio_ctrl_model (
  input wire logic clk,
  input wire cio_pkg::cio_word_t cmd_word,
  input wire logic cmd_stop,
  input wire logic cmd_lost,
  output cio_pkg::cio_word_t out_word,
  output logic ctrl_stop,
  output logic link_lost
);
  import cio_pkg::*;
  initial begin
    out_word = '0;
    ctrl_stop = 1'b0;
    link_lost = 1'b0;
  end
  always @(negedge clk) begin
    ctrl_stop <= cmd_stop;
    link_lost <= cmd_lost;
    // no valid data when stopped or cut off: churn, never hold
    if (cmd_stop || cmd_lost) out_word <= ~out_word;
    else out_word <= cmd_word;
  end
endmodule

// file: tb/tb_cio_channel_map.sv
// self-checking bench for the channel I/O mapping block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module tb_cio_channel_map;
  import cio_pkg::*;
  typedef struct packed {logic [2:0] sel; cio_word_t val;} cio_exp_t;
  logic clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_apply = 1'b0;
  logic dev_err = 1'b0, cmd_stop = 1'b0, cmd_lost = 1'b0, ctrl_stop;
  logic link_lost, cfg_done;
  cio_byte_t cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, cfg_err;
  cio_word_t pin_in = '0, overload = '0, cmd_word = '0, out_word;
  cio_word_t in_word, pin_out, pin_oe, do_fault, w, fs_w, got;
  cio_byte_t rd_a[5] = '{8'h25, 8'h30, 8'h31, 8'hC3, 8'hD0};
  cio_byte_t rd_d[5] = '{8'h05, 8'h50, 8'h00, 8'h02, 8'h00};
  cio_exp_t exp_q[$];
  cio_exp_t e;
  event look;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'h0AC6;
  int mp[16];
  int i;
  always #2 clk = ~clk;
  cio_channel_map #(.MS_CYCLES(10), .RESTART_MS(8'h03)) uut (
    .CLK(clk), .SYS_RST(sys_rst), .CFG_WR(cfg_wr), .CFG_ADDR(cfg_addr),
    .CFG_WDATA(cfg_wdata), .CFG_APPLY(cfg_apply), .CFG_RDATA(cfg_rdata),
    .CFG_DONE(cfg_done), .CFG_ERR(cfg_err), .OUT_WORD(out_word),
    .IN_WORD(in_word), .DEV_ERR(dev_err), .CTRL_STOP(ctrl_stop),
    .LINK_LOST(link_lost), .PIN_IN(pin_in), .OVERLOAD(overload),
    .PIN_OUT(pin_out), .PIN_OE(pin_oe), .DO_FAULT(do_fault)
  );
  cio_ctrl_model ctrl (
    .clk(clk), .cmd_word(cmd_word), .cmd_stop(cmd_stop),
    .cmd_lost(cmd_lost), .out_word(out_word), .ctrl_stop(ctrl_stop),
    .link_lost(link_lost)
  );
  // ----------------
  // helpers
  // ----------------
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic expect_out(input logic [2:0] sel, input cio_word_t val);
    exp_q.push_back('{sel, val});
    ->look;
  endtask
  // drains every pending note, so two notes in one step are never lost
  always @(look) begin
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      case (e.sel)
        3'h0: got = in_word;
        3'h1: got = pin_out;
        3'h2: got = {8'h00, cfg_err};
        3'h3: got = do_fault;
        3'h5: got = pin_oe;
        default: got = {8'h00, cfg_rdata};
      endcase
      `CHK(got, e.val)
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input cio_byte_t a, input cio_byte_t d);
    @(negedge clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(negedge clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic apply(input cio_byte_t err);
    @(negedge clk);
    cfg_apply <= 1'b1;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      #1;
      if (cfg_done === 1'b1) break;
    end
    @(negedge clk);
    cfg_apply <= 1'b0;
    if (i == 4) begin
      fail_count++;
      summarize();
    end
    expect_out(3'h2, {8'h00, err});
  endtask
  // bounded wait for the channel 0 trip flag to reach a level
  task automatic wait_flt(input logic lvl);
    for (i = 0; i < 100 && do_fault[0] !== lvl; i++) cyc(1);
    if (i == 100) begin
      fail_count++;
      summarize();
    end
  endtask
  function automatic logic [4:0] pos(input int m, input logic [3:0] c);
    case (m)
      1: pos = {1'b0, ~c[3], c[2:0]};
      2: pos = {1'b0, c[0], c[3:1]};
      3: pos = {1'b0, ~c[0], c[3:1]};
      4: pos = 5'(mp[c]);
      default: pos = {1'b0, c};
    endcase
  endfunction
  function automatic cio_word_t remap(input int m, input cio_word_t v,
                                      input logic to_pin);
    logic [4:0] b;
    remap = '0;
    for (int c = 0; c < 16; c++) begin
      b = pos(m, 4'(c));
      if (!b[4] && to_pin) remap[c] = v[b[3:0]];
      if (!b[4] && !to_pin) remap[b[3:0]] = v[c];
    end
  endfunction
  task automatic chk_in(input int m);
    repeat (2) begin
      w = 16'($random(seed));
      pin_in <= w;
      cyc(3);
      expect_out(3'h0, remap(m, w, 1'b0));
    end
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst <= 1'b0;
    expect_out(3'h2, 16'h0000);
    foreach (rd_a[k]) begin
      @(negedge clk);
      cfg_addr <= rd_a[k];
      cyc(2);
      expect_out(3'h4, {8'h00, rd_d[k]});
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h1F, 8'(m));
      apply(8'h00);
      chk_in(m);
    end
    for (int c = 0; c < 16; c++) begin
      mp[c] = (c == 5) ? 16 : 15 - c;
      wr(8'(8'h20 + c), 8'(mp[c]));
    end
    wr(8'h1F, 8'h04);
    apply(8'h00);
    chk_in(4);
    wr(8'h21, 8'h0F);
    apply(8'h01);
    chk_in(4);
    wr(8'h21, 8'h0E);
    wr(8'h1F, 8'h05);
    apply(8'h02);
    wr(8'h1F, 8'h04);
    apply(8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(8'(8'hC0 + c), 8'h01);
      wr(8'(8'h50 + c), 8'(c % 3));
    end
    apply(8'h00);
    for (int k = 0; k < 3; k++) begin
      w = 16'($random(seed));
      cmd_word <= w;
      cyc(4);
      fs_w = remap(4, w, 1'b1);
      expect_out(3'h1, fs_w);
      expect_out(3'h5, 16'hFFFF);
      for (int c = 0; c < 16; c++)
        if (c % 3 != 2) fs_w[c] = (c % 3 == 1);
      dev_err <= (k == 0);
      cmd_stop <= (k == 1);
      cmd_lost <= (k == 2);
      cyc(4);
      expect_out(3'h1, fs_w);
      dev_err <= 1'b0;
      cmd_stop <= 1'b0;
      cmd_lost <= 1'b0;
      cyc(3);
    end
    cmd_word <= 16'h0000;
    wr(8'h30, 8'h02);
    apply(8'h00);
    cmd_word <= 16'h8000;
    overload <= 16'h0001;
    cyc(40);
    expect_out(3'h3, 16'h0000);
    wait_flt(1'b1);
    cyc(2);
    expect_out(3'h1, 16'h0000);
    cmd_word <= 16'h0000;
    cyc(4);
    expect_out(3'h3, 16'h0000);
    cyc(2);
    // automatic restart: the trip lifts by itself and the pin retests
    wr(8'h60, 8'h01);
    apply(8'h00);
    cmd_word <= 16'h8000;
    wait_flt(1'b1);
    wait_flt(1'b0);
    cyc(2);
    expect_out(3'h1, 16'h0001);
    // channel 0 as inverted, filtered input; port 1 off; channel 4 aux
    pin_in <= 16'h0000;
    wr(8'hC0, 8'h02);
    wr(8'h80, 8'h01);
    wr(8'h90, 8'h02);
    wr(8'hC2, 8'h00);
    wr(8'hC4, 8'h04);
    apply(8'h00);
    cyc(2);
    expect_out(3'h0, 16'h8000);
    expect_out(3'h5, 16'hFFF2);
    expect_out(3'h1, 16'h0010);
    pin_in <= 16'h0001;
    cyc(5);
    expect_out(3'h0, 16'h8000);
    cyc(25);
    expect_out(3'h0, 16'h0000);
    cyc(2);
    summarize();
  end
endmodule
